// ### hdl/cvd_pkg.sv
// constants, types and helpers shared by the guard and result control block
package cvd_pkg;

    // ==========================================================
    // register map (byte addresses, one 32-bit word each)
    localparam int ADR_W = 8;
    localparam int DAT_W = 32;
    localparam logic [7:0] OFS_GUARD = 8'h00;
    localparam logic [7:0] OFS_CAP = 8'h04;
    localparam logic [7:0] OFS_RES0_HI = 8'h08;
    localparam logic [7:0] OFS_RES0_LO = 8'h0C;
    localparam logic [7:0] OFS_RES1_HI = 8'h10;
    localparam logic [7:0] OFS_RES1_LO = 8'h14;
    localparam logic [7:0] OFS_CTRL = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_TIMING = 8'h20;

    // ==========================================================
    // field positions
    localparam int GRD_B_BIT = 7;
    localparam int GRD_A_BIT = 6;
    localparam int GRD_POL_BIT = 5;
    localparam int CAP_W = 3;
    localparam int CTRL_ON_BIT = 0;
    localparam int CTRL_GO_BIT = 1;
    localparam int CTRL_DSEN_BIT = 2;
    localparam int CTRL_IPEN_BIT = 3;
    localparam int CTRL_JUST_BIT = 4;
    localparam int STAT_PAIR_BIT = 2;
    localparam int TIME_W = 7;
    localparam int TIM_PRE_LSB = 0;
    localparam int TIM_ACQ_LSB = 8;
    localparam int RES_W = 10;

    // ==========================================================
    // reset values and stage codes
    localparam logic [CAP_W-1:0] CAP_RST = 3'h0;
    localparam logic [TIME_W-1:0] TIME_RST = 7'h00;
    localparam logic [1:0] STG_IDLE = 2'h0;
    localparam logic [1:0] STG_PRE = 2'h1;
    localparam logic [1:0] STG_ACQ = 2'h2;
    localparam logic [1:0] STG_CONV = 2'h3;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_PRE,
        SEQ_ACQ,
        SEQ_CONV
    } cvd_seq_t;

    typedef struct packed {
        cvd_seq_t stage;
        logic [1:0] stat_stage;
        logic pair;
        logic on;
        logic go;
        logic dsen;
        logic ipen;
        logic just;
        logic grd_b_en;
        logic grd_a_en;
        logic grd_pol;
        logic [CAP_W-1:0] cap;
        logic [TIME_W-1:0] pre;
        logic [TIME_W-1:0] acq;
        logic [RES_W-1:0] res0;
        logic [RES_W-1:0] res1;
        logic start;
        logic grd_a;
        logic grd_b;
        logic grd_a_oe;
        logic grd_b_oe;
    } cvd_state_t;

    typedef struct packed {
        logic ack;
        logic [DAT_W-1:0] dat;
    } cvd_wb_state_t;

    // ==========================================================
    // result byte views; unused positions read as zero
    function automatic logic [7:0] cvd_res_read(input logic [RES_W-1:0] raw,
                                                input logic just, input logic hi);
        logic [7:0] b;
        if (!just) begin
            b = hi ? raw[9:2] : {raw[1:0], 6'h00};
        end else begin
            b = hi ? {6'h00, raw[9:8]} : raw[7:0];
        end
        return b;
    endfunction

    // software write into one byte view; reserved bits are dropped
    function automatic logic [RES_W-1:0] cvd_res_write(input logic [RES_W-1:0] raw,
                                                       input logic just, input logic hi,
                                                       input logic [7:0] b);
        logic [RES_W-1:0] v;
        if (!just) begin
            v = hi ? {b, raw[1:0]} : {raw[9:2], b[7:6]};
        end else begin
            v = hi ? {b[1:0], raw[7:0]} : {raw[9:8], b};
        end
        return v;
    endfunction

endpackage

// ### hdl/cvd_regbus_if.sv
// internal register access path between the bus front end and the core
`timescale 1ns/1ps
interface cvd_regbus_if;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [31:0] rdata;
    modport front (output wr, output addr, output wdata, input rdata);
    modport core (input wr, input addr, input wdata, output rdata);
endinterface

// ### hdl/cvd_wb_front.sv
// classic wishbone slave front end: one wait state, registered ack and data
`timescale 1ns/1ps
module cvd_wb_front (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    cvd_regbus_if.front bus
);
    cvd_pkg::cvd_wb_state_t r, nxt;

    // write commits on the edge where the master samples ack
    assign bus.wr = r.ack & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0];
    assign bus.addr = wb_adr_i;
    assign bus.wdata = wb_dat_i[7:0];

    always_comb begin
        nxt = r;
        nxt.ack = wb_cyc_i & wb_stb_i & ~r.ack;
        if (wb_cyc_i && wb_stb_i && !r.ack) begin
            nxt.dat = wb_we_i ? 32'h0000_0000 : bus.rdata;
        end
        if (rst_i) begin
            nxt.ack = 1'b0;
            nxt.dat = 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_i) begin
        r <= nxt;
    end

    assign wb_ack_o = r.ack;
    assign wb_dat_o = r.dat;
endmodule

// ### hdl/cvd_stage_timer.sv
// down counter timing the pre-charge and acquisition stages
`timescale 1ns/1ps
module cvd_stage_timer #(
    parameter int W = 7
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic load_i,
    input wire logic [W-1:0] count_i,
    output logic expired_o
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } cvd_tmr_state_t;

    cvd_tmr_state_t r, nxt;

    if (W < 1 || W > 16) begin : g_bad_width
        $error("stage timer width out of range");
    end

    always_comb begin
        nxt = r;
        if (load_i) begin
            nxt.cnt = count_i;
        end else if (r.cnt != '0) begin
            nxt.cnt = r.cnt - 1'b1;
        end
        if (rst_i) begin
            nxt.cnt = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        r <= nxt;
    end

    // a count of zero or one still gives a single-cycle stage
    assign expired_o = (r.cnt <= W'(1));
endmodule

// ### hdl/cvd_guard_ctrl.sv
// guard ring drive, extra capacitor select and result registers of the cvd sequencer
//
// Decided for this implementation: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
module cvd_guard_ctrl (
    input wire logic clk_i,
    input wire logic rst_i,
    // ==========================================================
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // ==========================================================
    // converter core
    output logic conv_start_o,
    input wire logic conv_done_i,
    input wire logic [9:0] conv_result_i,
    // ==========================================================
    // pins and analog controls
    output logic guard_a_pin_o,
    output logic guard_a_oe_o,
    output logic guard_b_pin_o,
    output logic guard_b_oe_o,
    output logic [2:0] extra_cap_select_o,
    output logic converter_on_o,
    output logic [1:0] sequence_stage_o,
    output logic result_pair_indicator_o
);
    cvd_pkg::cvd_state_t r, nxt;
    cvd_regbus_if bus ();
    logic tmr_load;
    logic [cvd_pkg::TIME_W-1:0] tmr_count;
    logic tmr_expired;
    logic pol_eff;
    logic a_level;

    // ==========================================================
    // sub blocks
    cvd_wb_front u_front (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .bus(bus.front)
    );

    cvd_stage_timer #(
        .W(cvd_pkg::TIME_W)
    ) u_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(tmr_load),
        .count_i(tmr_count),
        .expired_o(tmr_expired)
    );

    // ==========================================================
    // register read mux, unmapped addresses read zero
    always_comb begin
        bus.rdata = 32'h0000_0000;
        unique case (bus.addr)
            cvd_pkg::OFS_GUARD: begin
                bus.rdata[cvd_pkg::GRD_B_BIT] = r.grd_b_en;
                bus.rdata[cvd_pkg::GRD_A_BIT] = r.grd_a_en;
                bus.rdata[cvd_pkg::GRD_POL_BIT] = r.grd_pol;
            end
            cvd_pkg::OFS_CAP: begin
                bus.rdata[cvd_pkg::CAP_W-1:0] = r.cap;
            end
            cvd_pkg::OFS_RES0_HI: begin
                bus.rdata[7:0] = cvd_pkg::cvd_res_read(r.res0, r.just, 1'b1);
            end
            cvd_pkg::OFS_RES0_LO: begin
                bus.rdata[7:0] = cvd_pkg::cvd_res_read(r.res0, r.just, 1'b0);
            end
            cvd_pkg::OFS_RES1_HI: begin
                bus.rdata[7:0] = cvd_pkg::cvd_res_read(r.res1, r.just, 1'b1);
            end
            cvd_pkg::OFS_RES1_LO: begin
                bus.rdata[7:0] = cvd_pkg::cvd_res_read(r.res1, r.just, 1'b0);
            end
            cvd_pkg::OFS_CTRL: begin
                bus.rdata[cvd_pkg::CTRL_ON_BIT] = r.on;
                bus.rdata[cvd_pkg::CTRL_GO_BIT] = r.go;
                bus.rdata[cvd_pkg::CTRL_DSEN_BIT] = r.dsen;
                bus.rdata[cvd_pkg::CTRL_IPEN_BIT] = r.ipen;
                bus.rdata[cvd_pkg::CTRL_JUST_BIT] = r.just;
            end
            cvd_pkg::OFS_STATUS: begin
                bus.rdata[cvd_pkg::STAT_PAIR_BIT] = r.pair;
                bus.rdata[1:0] = r.stat_stage;
            end
            cvd_pkg::OFS_TIMING: begin
                bus.rdata[cvd_pkg::TIM_PRE_LSB +: cvd_pkg::TIME_W] = r.pre;
                bus.rdata[cvd_pkg::TIM_ACQ_LSB +: cvd_pkg::TIME_W] = r.acq;
            end
            default: begin
                bus.rdata = 32'h0000_0000;
            end
        endcase
    end

    // ==========================================================
    // sequencer, register writes and pin levels
    always_comb begin
        nxt = r;
        nxt.start = 1'b0;
        tmr_load = 1'b0;
        tmr_count = r.pre;
        pol_eff = 1'b0;
        a_level = 1'b0;

        unique case (r.stage)
            cvd_pkg::SEQ_IDLE: begin
                if (r.go && r.on) begin
                    nxt.stage = cvd_pkg::SEQ_PRE;
                    tmr_load = 1'b1;
                end
            end
            cvd_pkg::SEQ_PRE: begin
                if (tmr_expired) begin
                    nxt.stage = cvd_pkg::SEQ_ACQ;
                    tmr_load = 1'b1;
                    tmr_count = r.acq;
                end
            end
            cvd_pkg::SEQ_ACQ: begin
                if (tmr_expired) begin
                    nxt.stage = cvd_pkg::SEQ_CONV;
                    nxt.start = 1'b1;
                end
            end
            cvd_pkg::SEQ_CONV: begin
                if (conv_done_i) begin
                    if (r.pair) begin
                        nxt.res1 = conv_result_i;
                    end else begin
                        nxt.res0 = conv_result_i;
                    end
                    if (r.dsen && !r.pair) begin
                        // go stays set; the second sample follows at once
                        nxt.pair = 1'b1;
                        nxt.stage = cvd_pkg::SEQ_PRE;
                        tmr_load = 1'b1;
                    end else begin
                        nxt.go = 1'b0;
                        nxt.pair = 1'b0;
                        nxt.stage = cvd_pkg::SEQ_IDLE;
                    end
                end
            end
        endcase

        // a software write lands after the sequencer, so it wins a same-cycle clash
        if (bus.wr) begin
            unique case (bus.addr)
                cvd_pkg::OFS_GUARD: begin
                    nxt.grd_b_en = bus.wdata[cvd_pkg::GRD_B_BIT];
                    nxt.grd_a_en = bus.wdata[cvd_pkg::GRD_A_BIT];
                    nxt.grd_pol = bus.wdata[cvd_pkg::GRD_POL_BIT];
                end
                cvd_pkg::OFS_CAP: begin
                    nxt.cap = bus.wdata[cvd_pkg::CAP_W-1:0];
                end
                cvd_pkg::OFS_RES0_HI: begin
                    nxt.res0 = cvd_pkg::cvd_res_write(r.res0, r.just, 1'b1, bus.wdata);
                end
                cvd_pkg::OFS_RES0_LO: begin
                    nxt.res0 = cvd_pkg::cvd_res_write(r.res0, r.just, 1'b0, bus.wdata);
                end
                cvd_pkg::OFS_RES1_HI: begin
                    nxt.res1 = cvd_pkg::cvd_res_write(r.res1, r.just, 1'b1, bus.wdata);
                end
                cvd_pkg::OFS_RES1_LO: begin
                    nxt.res1 = cvd_pkg::cvd_res_write(r.res1, r.just, 1'b0, bus.wdata);
                end
                cvd_pkg::OFS_CTRL: begin
                    nxt.on = bus.wdata[cvd_pkg::CTRL_ON_BIT];
                    nxt.go = bus.wdata[cvd_pkg::CTRL_GO_BIT] & bus.wdata[cvd_pkg::CTRL_ON_BIT];
                    nxt.dsen = bus.wdata[cvd_pkg::CTRL_DSEN_BIT];
                    nxt.ipen = bus.wdata[cvd_pkg::CTRL_IPEN_BIT];
                    nxt.just = bus.wdata[cvd_pkg::CTRL_JUST_BIT];
                end
                cvd_pkg::OFS_TIMING: begin
                    nxt.pre = bus.wdata[cvd_pkg::TIM_PRE_LSB +: cvd_pkg::TIME_W];
                    nxt.acq = bus.wdata[cvd_pkg::TIM_ACQ_LSB +: cvd_pkg::TIME_W];
                end
                default: begin
                    nxt.go = nxt.go;
                end
            endcase
        end

        // clearing go or switching off aborts the running sequence
        if (!nxt.go || !nxt.on) begin
            nxt.stage = cvd_pkg::SEQ_IDLE;
            nxt.pair = 1'b0;
            nxt.start = 1'b0;
        end

        // controls clear on reset; results are left untouched
        if (rst_i) begin
            nxt.stage = cvd_pkg::SEQ_IDLE;
            nxt.pair = 1'b0;
            nxt.on = 1'b0;
            nxt.go = 1'b0;
            nxt.dsen = 1'b0;
            nxt.ipen = 1'b0;
            nxt.just = 1'b0;
            nxt.grd_b_en = 1'b0;
            nxt.grd_a_en = 1'b0;
            nxt.grd_pol = 1'b0;
            nxt.cap = cvd_pkg::CAP_RST;
            nxt.pre = cvd_pkg::TIME_RST;
            nxt.acq = cvd_pkg::TIME_RST;
            nxt.start = 1'b0;
        end

        unique case (nxt.stage)
            cvd_pkg::SEQ_IDLE: nxt.stat_stage = cvd_pkg::STG_IDLE;
            cvd_pkg::SEQ_PRE: nxt.stat_stage = cvd_pkg::STG_PRE;
            cvd_pkg::SEQ_ACQ: nxt.stat_stage = cvd_pkg::STG_ACQ;
            cvd_pkg::SEQ_CONV: nxt.stat_stage = cvd_pkg::STG_CONV;
        endcase

        // inversion only affects the drive, never the stored polarity bit
        pol_eff = nxt.grd_pol ^ (nxt.pair & nxt.dsen & nxt.ipen);
        // guard A flips once pre-charge ends and stays flipped through conversion
        a_level = (nxt.stage == cvd_pkg::SEQ_ACQ || nxt.stage == cvd_pkg::SEQ_CONV) ?
                  ~pol_eff : pol_eff;
        // drive lasts the whole time the converter is on, idle included
        nxt.grd_a_oe = nxt.on & nxt.grd_a_en;
        nxt.grd_b_oe = nxt.on & nxt.grd_b_en;
        nxt.grd_a = nxt.grd_a_oe & a_level;
        nxt.grd_b = nxt.grd_b_oe & pol_eff;
    end

    always_ff @(posedge clk_i) begin
        r <= nxt;
    end

    // ==========================================================
    // outputs, each straight from a state flop
    assign conv_start_o = r.start;
    assign guard_a_pin_o = r.grd_a;
    assign guard_a_oe_o = r.grd_a_oe;
    assign guard_b_pin_o = r.grd_b;
    assign guard_b_oe_o = r.grd_b_oe;
    assign extra_cap_select_o = r.cap;
    assign converter_on_o = r.on;
    assign sequence_stage_o = r.stat_stage;
    assign result_pair_indicator_o = r.pair;
endmodule

// ### verification/cvd_guard_ctrl_properties.sv
// concurrent checks on the ports of the guard and result control block
`timescale 1ns/1ps
module cvd_guard_ctrl_properties (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic conv_start_o,
    input wire logic guard_a_pin_o,
    input wire logic guard_a_oe_o,
    input wire logic guard_b_pin_o,
    input wire logic guard_b_oe_o,
    input wire logic converter_on_o,
    input wire logic [1:0] sequence_stage_o,
    input wire logic result_pair_indicator_o
);
    // ====================
    // properties
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_b_off; !guard_b_oe_o |-> !guard_b_pin_o; endproperty
    a_b_off: assert property (p_b_off)
        else $error("guard b level shown while not driven");
    property p_a_off; !guard_a_oe_o |-> !guard_a_pin_o; endproperty
    a_a_off: assert property (p_a_off)
        else $error("guard a level shown while not driven");
    property p_on_drive; (guard_a_oe_o || guard_b_oe_o) |-> converter_on_o; endproperty
    a_on_drive: assert property (p_on_drive)
        else $error("guard driven with converter off");
    property p_pre_same;
        (sequence_stage_o == 2'h1 && guard_a_oe_o && guard_b_oe_o) |->
            guard_a_pin_o == guard_b_pin_o;
    endproperty
    a_pre_same: assert property (p_pre_same)
        else $error("guards differ in pre-charge");
    property p_a_flip;
        (sequence_stage_o == 2'h2 && $past(sequence_stage_o) == 2'h1 && guard_a_oe_o &&
            $past(guard_a_oe_o)) |-> guard_a_pin_o != $past(guard_a_pin_o);
    endproperty
    a_a_flip: assert property (p_a_flip)
        else $error("guard a did not flip entering acquisition");
    property p_split;
        (sequence_stage_o[1] && guard_a_oe_o && guard_b_oe_o) |->
            guard_a_pin_o != guard_b_pin_o;
    endproperty
    a_split: assert property (p_split)
        else $error("guard a not opposite after pre-charge");
    property p_idle_pair; sequence_stage_o == 2'h0 |-> !result_pair_indicator_o; endproperty
    a_idle_pair: assert property (p_idle_pair)
        else $error("pair indicator set while idle");
    property p_start;
        conv_start_o |-> (sequence_stage_o == 2'h3 && $past(sequence_stage_o) == 2'h2)
            ##1 !conv_start_o;
    endproperty
    a_start: assert property (p_start)
        else $error("start pulse outside first conversion cycle");
    property p_order;
        ($changed(sequence_stage_o) && sequence_stage_o != 2'h0) |->
            sequence_stage_o == $past(sequence_stage_o) + 2'h1 ||
            (sequence_stage_o == 2'h1 && $past(sequence_stage_o) == 2'h3);
    endproperty
    a_order: assert property (p_order)
        else $error("stage sequence out of order");
    property p_ack; (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o; endproperty
    a_ack: assert property (p_ack)
        else $error("bus answer not a single cycle after request");
endmodule

// ### verification/cvd_conv_model.sv
// converter stand-in: answers each start pulse after a set delay
`timescale 1ns/1ps
module cvd_conv_model (
    input wire logic clk_i,
    input wire logic start_i,
    input wire logic pair_i,
    input wire logic [7:0] dly_i,
    input wire logic [9:0] res0_i,
    input wire logic [9:0] res1_i,
    output logic done_o,
    output logic [9:0] result_o
);
    // ====================
    // behaviour
    int cnt = -1;
    logic [9:0] last = 10'h000;
    always @(posedge clk_i) begin
        done_o <= 1'b0;
        // result lines carry no meaning between answers, so never show a stale value
        result_o <= ~last;
        if (start_i) begin
            cnt <= dly_i;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end else if (cnt == 0) begin
            cnt <= -1;
            done_o <= 1'b1;
            last <= pair_i ? res1_i : res0_i;
            result_o <= pair_i ? res1_i : res0_i;
        end
    end
endmodule

// ### verification/tb_cvd_guard_ctrl.sv
// self-checking bench for the guard and result control block
`timescale 1ns/1ps
module tb_cvd_guard_ctrl;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, conv_start_o, conv_done_i, converter_on_o, result_pair_indicator_o;
    logic guard_a_pin_o, guard_a_oe_o, guard_b_pin_o, guard_b_oe_o;
    logic [9:0] conv_result_i;
    logic [2:0] extra_cap_select_o;
    logic [1:0] sequence_stage_o;
    logic [7:0] dly = 8'h03;
    logic [9:0] r0 = 10'h2D5;
    logic [9:0] r1 = 10'h0A6;
    logic [7:0] res_exp [2][4] = '{'{8'hB5, 8'h40, 8'h29, 8'h80}, '{8'h02, 8'hD5, 8'h00, 8'hA6}};
    logic [31:0] q;
    logic [3:0] sel_v = 4'hF;
    int error_cnt = 0;
    int checked = 0;
    int cycles = 0;

    // ====================
    // instances
    cvd_guard_ctrl cvd_guard_ctrl_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .conv_start_o, .conv_done_i, .conv_result_i,
        .guard_a_pin_o, .guard_a_oe_o, .guard_b_pin_o, .guard_b_oe_o, .extra_cap_select_o,
        .converter_on_o, .sequence_stage_o, .result_pair_indicator_o);
    cvd_conv_model cvd_conv_model_i (.clk_i, .start_i(conv_start_o),
        .pair_i(result_pair_indicator_o), .dly_i(dly), .res0_i(r0), .res1_i(r1),
        .done_o(conv_done_i), .result_o(conv_result_i));

    // ====================
    // clock, watchdog and shared tasks
    initial forever #12.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    task automatic report_and_stop;
        if (error_cnt == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // entered right after a rising edge; request held until ack is sampled
    task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= sel_v;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d); xfer(1'b1, a, d); endtask
    task automatic rd(input logic [7:0] a); xfer(1'b0, a, 32'h0000_0000); endtask
    task automatic wait_stg(input logic [1:0] s, input logic p);
        while (!(sequence_stage_o === s && result_pair_indicator_o === p)) @(posedge clk_i);
    endtask

    // ====================
    // scenarios
    task automatic t_reset_values;
        rd(8'h00); chk("guard reset", q, 32'h0000_0000);
        rd(8'h04); chk("cap reset", q, 32'h0000_0000);
        rd(8'h40); chk("unmapped", q, 32'h0000_0000);
    endtask
    // pin direction bits sit outside the block; oe is taken as the drive request
    task automatic t_guard_enables;
        wr(8'h00, 32'h0000_00FF);
        rd(8'h00); chk("guard bits", q, 32'h0000_00E0);
        chk("oe while off", 32'({guard_a_oe_o, guard_b_oe_o}), 32'h0000_0000);
        wr(8'h18, 32'h0000_0001);
        @(posedge clk_i);
        chk("idle drive", 32'({guard_a_oe_o, guard_b_oe_o, guard_a_pin_o, guard_b_pin_o}),
            32'h0000_000F);
        wr(8'h00, 32'h0000_0040);
        @(posedge clk_i);
        chk("a only", 32'({guard_a_oe_o, guard_b_oe_o, guard_a_pin_o, guard_b_pin_o}),
            32'h0000_0008);
    endtask
    task automatic t_cap_codes;
        for (int i = 0; i < 8; i++) begin
            wr(8'h04, {24'h00_0000, 5'h1F, i[2:0]});
            rd(8'h04); chk("cap read", q, {29'h0000_0000, i[2:0]});
            chk("cap out", 32'(extra_cap_select_o), {29'h0000_0000, i[2:0]});
        end
        // a write with byte lane 0 off must leave the register alone
        sel_v = 4'hE;
        wr(8'h04, 32'h0000_0002);
        sel_v = 4'hF;
        rd(8'h04); chk("lane off write", q, 32'h0000_0007);
    endtask
    task automatic t_double_sample;
        wr(8'h20, 32'h0000_031E);
        wr(8'h00, 32'h0000_00E0);
        wr(8'h18, 32'h0000_000F);
        wait_stg(2'h1, 1'b0);
        chk("pre pins", 32'({guard_a_pin_o, guard_b_pin_o}), 32'h0000_0003);
        wait_stg(2'h2, 1'b0);
        chk("acq pins", 32'({guard_a_pin_o, guard_b_pin_o}), 32'h0000_0001);
        wait_stg(2'h3, 1'b0);
        chk("start pulse", 32'({conv_start_o, sequence_stage_o}), 32'h0000_0007);
        wait_stg(2'h1, 1'b1);
        chk("second pins", 32'({guard_a_pin_o, guard_b_pin_o}), 32'h0000_0000);
        rd(8'h18); chk("go held", q & 32'h0000_0002, 32'h0000_0002);
        rd(8'h1C); chk("status", q, 32'h0000_0005);
        wait_stg(2'h0, 1'b0);
        rd(8'h18); chk("go done", q & 32'h0000_0002, 32'h0000_0000);
        rd(8'h00); chk("pol kept", q, 32'h0000_00E0);
        for (int j = 0; j < 2; j++) begin
            wr(8'h18, {27'h000_0000, j[0], 4'h1});
            for (int k = 0; k < 4; k++) begin
                rd(8'h08 + 8'(4 * k));
                chk("result view", q, 32'(res_exp[j][k]));
            end
        end
    endtask
    task automatic t_result_write;
        wr(8'h08, 32'h0000_00FF);
        rd(8'h08); chk("reserved high", q, 32'h0000_0003);
        wr(8'h18, 32'h0000_0001);
        rd(8'h08); chk("written high", q, 32'h0000_00F5);
    endtask
    task automatic t_reset_keep;
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("outs reset", 32'({guard_a_oe_o, guard_b_oe_o, converter_on_o, sequence_stage_o}),
            32'h0000_0000);
        rd(8'h00); chk("guard cleared", q, 32'h0000_0000);
        rd(8'h04); chk("cap cleared", q, 32'h0000_0000);
        rd(8'h08); chk("result kept", q, 32'h0000_00F5);
    endtask
    // single mode: one conversion, go drops, second pair untouched
    task automatic t_single_sample;
        r0 <= 10'h155;
        r1 <= 10'h3FF;
        wr(8'h18, 32'h0000_000B);
        wait_stg(2'h3, 1'b0);
        wait_stg(2'h0, 1'b0);
        rd(8'h18); chk("single go done", q, 32'h0000_0009);
        rd(8'h08); chk("single result", q, 32'h0000_0055);
        rd(8'h10); chk("second pair kept", q, 32'h0000_0029);
    endtask

    // ====================
    // main sequence
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset_values();
        t_guard_enables();
        t_cap_codes();
        t_double_sample();
        t_result_write();
        t_reset_keep();
        t_single_sample();
        report_and_stop();
    end
endmodule

bind cvd_guard_ctrl cvd_guard_ctrl_properties cvd_guard_ctrl_properties_i (.clk_i, .rst_i,
    .wb_cyc_i, .wb_stb_i, .wb_ack_o, .conv_start_o, .guard_a_pin_o, .guard_a_oe_o,
    .guard_b_pin_o, .guard_b_oe_o, .converter_on_o, .sequence_stage_o, .result_pair_indicator_o);
